// *** dom_pkg.sv ***
// Constants, register map and scaling figures of the output terminal mapper.
// Assumes a single 100 MHz core clock and an APB register bus.
package dom_pkg;

	// ****************************************************
	// Clock and delay tick
	// ****************************************************
	localparam int CLK_HZ = 100000000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W = 24;
	localparam int DLY_W = 16;
	localparam logic [DLY_W-1:0] DLY_MAX = 16'h8ca0;
	localparam logic [DLY_W-1:0] DLY_RESET = 16'h0000;

	// ****************************************************
	// Terminals
	// ****************************************************
	localparam int NUM_DO = 4;
	localparam int SEL_W = 6;
	localparam logic [SEL_W-1:0] SEL_AIN_GUARD = 6'h1f;
	localparam logic [SEL_W-1:0] SEL_LOAD_LOST = 6'h20;
	localparam logic [SEL_W-1:0] SEL_REVERSE = 6'h21;
	localparam logic [SEL_W-1:0] SEL_HEATSINK = 6'h23;
	localparam logic [SEL_W-1:0] SEL_LOW_LIMIT = 6'h25;
	localparam logic [SEL_W-1:0] SEL_FAULT_RUN = 6'h26;
	localparam logic [SEL_W-1:0] SEL_USER_ONE = 6'h29;
	localparam logic [SEL_W-1:0] SEL_USER_TWO = 6'h2a;

	// ****************************************************
	// Analog scaling: quantities are 0..10000 full scale
	// ****************************************************
	localparam int Q_W = 16;
	localparam int AO_W = 16;
	localparam logic signed [Q_W-1:0] FULL_SCALE = 16'sh2710;
	localparam logic signed [Q_W-1:0] GAIN_ONE = 16'sh0064;
	localparam logic signed [Q_W-1:0] GAIN_LIM = 16'sh03e8;
	localparam logic signed [Q_W-1:0] OFS_LIM = 16'sh03e8;
	localparam int GAIN_DIV = 100;
	localparam int OFS_MUL = 10;
	localparam int NUM_SRC = 16;
	localparam logic [3:0] AO1_SRC_RESET = 4'h0;
	localparam logic [3:0] AO2_SRC_RESET = 4'h1;
	localparam logic [3:0] SRC_COMM = 4'hc;
	localparam logic [Q_W-1:0] PULSE_MAX_RESET = 16'h1388;

	// ****************************************************
	// Register byte offsets
	// ****************************************************
	localparam logic [7:0] R_SEL = 8'h00;
	localparam logic [7:0] R_POL = 8'h04;
	localparam logic [7:0] R_AO_SRC = 8'h08;
	localparam logic [7:0] R_AO1_GAIN = 8'h0c;
	localparam logic [7:0] R_AO1_OFS = 8'h10;
	localparam logic [7:0] R_AO2_GAIN = 8'h14;
	localparam logic [7:0] R_AO2_OFS = 8'h18;
	localparam logic [7:0] R_PULSE_MAX = 8'h1c;
	localparam logic [7:0] R_GUARD = 8'h20;
	localparam logic [7:0] R_HEAT = 8'h24;
	localparam logic [7:0] R_STATUS = 8'h28;
	localparam logic [7:0] R_ON_DLY = 8'h40;
	localparam logic [7:0] R_OFF_DLY = 8'h50;

	// Clamp a signed value to +/- limit
	function automatic logic signed [Q_W-1:0] clamp_sym(
		input logic signed [31:0] v, input logic signed [Q_W-1:0] lim);
		if (v > 32'(lim))
			return lim;
		else if (v < -32'(lim))
			return -lim;
		else
			return v[Q_W-1:0];
	endfunction

endpackage

// *** dom_delay.sv ***
// One terminal's turn-on/turn-off delay, counting 0.1 s ticks.
// Assumes tick is a one-cycle pulse from a shared divider.
`timescale 1ns/100ps
module dom_delay
	import dom_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst, // async reset, high
	input wire logic tick, // 0.1 s enable
	input wire logic cond, // raw condition
	input wire logic [dom_pkg::DLY_W-1:0] on_dly, // turn-on ticks
	input wire logic [dom_pkg::DLY_W-1:0] off_dly, // turn-off ticks
	output logic state // delayed condition
);
	typedef struct packed {
		logic out;
		logic [DLY_W-1:0] cnt;
	} dom_dly_t;

	dom_dly_t s, next_s;
	logic [DLY_W-1:0] target;

	assign target = s.out ? off_dly : on_dly;
	assign state = s.out;

	always_comb begin
		next_s = s;
		if (cond == s.out) begin
			next_s.cnt = '0; // RULE16
		end else if (target == '0) begin
			next_s.out = cond; // RULE13 RULE14
			next_s.cnt = '0;
		end else if (tick) begin
			if (s.cnt + 1'b1 >= target) begin
				next_s.out = cond; // RULE13 RULE14
				next_s.cnt = '0;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0; // RULE17
		else
			s <= next_s;
	end

	cancel_hold_a: assert property (@(posedge clk) disable iff (rst)
		(cond == s.out) |=> (s.out == $past(s.out))) // RULE16
		else $error("output changed while condition matched");
	zero_on_a: assert property (@(posedge clk) disable iff (rst)
		(!s.out && cond && on_dly == '0) |=> s.out) // RULE13
		else $error("zero turn-on delay not immediate");
	zero_off_a: assert property (@(posedge clk) disable iff (rst)
		(s.out && !cond && off_dly == '0) |=> !s.out) // RULE14
		else $error("zero turn-off delay not immediate");
endmodule

// *** dom_scale.sv ***
// Analog output scaling Y = kX + b, with clamping to output range.
// Assumes X in 0..FULL_SCALE, gain in hundredths, offset in 0.1 %.
`timescale 1ns/100ps
module dom_scale
	import dom_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst, // async reset, high
	input wire logic signed [dom_pkg::Q_W-1:0] std_x, // standard output
	input wire logic signed [dom_pkg::Q_W-1:0] gain, // gain x100
	input wire logic signed [dom_pkg::Q_W-1:0] ofs, // offset x0.1 %
	output logic [dom_pkg::AO_W-1:0] y // 0..FULL_SCALE
);
	typedef struct packed {
		logic [AO_W-1:0] y;
	} dom_scl_t;

	dom_scl_t s, next_s;
	logic signed [31:0] prod;
	logic signed [31:0] sum;

	assign y = s.y;

	always_comb begin
		next_s = s;
		prod = 32'(std_x) * 32'(gain) / GAIN_DIV; // RULE11
		sum = prod + 32'(ofs) * OFS_MUL; // RULE12
		// The pin cannot go below zero or above full scale
		if (sum < 0)
			next_s.y = '0;
		else if (sum > 32'(FULL_SCALE))
			next_s.y = AO_W'(FULL_SCALE);
		else
			next_s.y = sum[AO_W-1:0]; // RULE8
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	unity_map_a: assert property (@(posedge clk) disable iff (rst)
		// Reset still sampled high on the release edge clears y there
		(!rst && gain == GAIN_ONE && ofs == '0 && std_x >= 0 &&
		std_x <= FULL_SCALE)
		|=> (y == AO_W'($past(std_x)))) // RULE8
		else $error("unity scaling does not pass the value");
	range_a: assert property (@(posedge clk) disable iff (rst)
		y <= AO_W'(FULL_SCALE)) // RULE11
		else $error("analog output above full scale");
endmodule

// *** dom_mapper.sv ***
// Output terminal mapper: condition selection, delays, polarity, analog.
// Assumes drive conditions and quantities arrive synchronous to CORE_CLK.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// How it works
// (RULE1) Code 31: on while analog input one is above upper or below lower guard
// (RULE2) Code 32: on while the drive is in the load-lost state
// (RULE3) Code 33: on while the drive runs in reverse
// (RULE4) Code 35: on once heatsink reading reaches heatsink threshold
// (RULE5) Code 37: on while frequency is at lower limit, also when stopped
// (RULE6) Code 38: on while a fault exists under continue-operation handling
// (RULE7) Codes 41 and 42 route user comparison one and two
// (RULE8) Unity gain, zero offset: output spans zero to full scale
// (RULE9) Source selector maps codes to quantities; defaults codes 0 and 1
// (RULE10) Pulse output scales to a max frequency, default 50 kHz
// (RULE11) Analog value is gain times standard plus offset, gain -10..10
// (RULE12) Offset -100..100 percent, 100 percent means full scale shift
// (RULE13) Each digital output delays turning on by 0..3600 s, default 0
// (RULE14) Each digital output delays turning off by its own 0..3600 s
// (RULE15) Per-terminal polarity: positive closes on active, negative opens
// (RULE16) Condition reverting before delay expiry cancels the pending change
// (RULE17) Delays count 0.1 s ticks; reset leaves all outputs inactive
module dom_mapper
	import dom_pkg::*;
(
	input wire logic CORE_CLK, // 100 MHz clock
	input wire logic RST, // async reset, high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	input wire logic [dom_pkg::Q_W-1:0] ANALOG_INPUT_ONE, // input value
	input wire logic LOAD_LOST, // load-lost state
	input wire logic RUN_REVERSE, // running in reverse
	input wire logic [dom_pkg::Q_W-1:0] HEATSINK_TEMPERATURE_READING, // temp
	input wire logic AT_LOWER_LIMIT, // frequency at lower limit or stopped
	input wire logic FAULT_CONTINUE, // fault while continuing operation
	input wire logic USER_COND_ONE, // user comparison one
	input wire logic USER_COND_TWO, // user comparison two
	input wire logic [dom_pkg::NUM_SRC*dom_pkg::Q_W-1:0] QUANTITY, // sources
	output logic OPEN_COLLECTOR_OUTPUT, // terminal drive
	output logic RELAY_OUTPUT_ONE, // relay coil
	output logic RELAY_OUTPUT_TWO, // relay coil
	output logic VIRTUAL_DIGITAL_OUTPUT, // virtual terminal
	output logic [dom_pkg::AO_W-1:0] ANALOG_OUTPUT_ONE, // 0..10000 scale
	output logic [dom_pkg::AO_W-1:0] ANALOG_OUTPUT_TWO, // 0..10000 scale
	output logic [dom_pkg::Q_W-1:0] PULSE_FREQUENCY_OUTPUT // 10 Hz units
);
	import dom_pkg::*;

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		logic [NUM_DO-1:0][SEL_W-1:0] sel;
		logic [NUM_DO-1:0] pol;
		logic [3:0] ao1_src;
		logic [3:0] ao2_src;
		logic [3:0] pulse_src;
		logic signed [Q_W-1:0] ao1_gain;
		logic signed [Q_W-1:0] ao1_ofs;
		logic signed [Q_W-1:0] ao2_gain;
		logic signed [Q_W-1:0] ao2_ofs;
		logic [Q_W-1:0] pulse_max;
		logic [Q_W-1:0] guard_lower;
		logic [Q_W-1:0] guard_upper;
		logic [Q_W-1:0] heatsink_threshold;
		logic [NUM_DO-1:0][DLY_W-1:0] on_dly;
		logic [NUM_DO-1:0][DLY_W-1:0] off_dly;
		logic [TICK_W-1:0] div;
		logic tick;
		logic [NUM_DO-1:0] pins;
		logic [Q_W-1:0] pulse;
		logic [31:0] rdata;
	} dom_state_t;

	dom_state_t s, next_s;
	logic [NUM_DO-1:0] cond;
	logic [NUM_DO-1:0] dly_state;
	logic signed [Q_W-1:0] std1;
	logic signed [Q_W-1:0] std2;
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	// Select one quantity; a communication value below zero is taken as zero
	function automatic logic signed [Q_W-1:0] pick(input logic [3:0] code);
		logic [Q_W-1:0] q;
		q = QUANTITY[code*Q_W +: Q_W];
		if (code == SRC_COMM)
			return (signed'(q) < 0) ? '0 : signed'(q); // RULE9
		else
			return signed'(q); // RULE9
	endfunction

	// Decode one terminal's selection code to its condition
	function automatic logic decode(input logic [SEL_W-1:0] code);
		unique case (code)
			SEL_AIN_GUARD: return (ANALOG_INPUT_ONE > s.guard_upper) ||
				(ANALOG_INPUT_ONE < s.guard_lower); // RULE1
			SEL_LOAD_LOST: return LOAD_LOST; // RULE2
			SEL_REVERSE: return RUN_REVERSE; // RULE3
			SEL_HEATSINK: return HEATSINK_TEMPERATURE_READING >=
				s.heatsink_threshold; // RULE4
			SEL_LOW_LIMIT: return AT_LOWER_LIMIT; // RULE5
			SEL_FAULT_RUN: return FAULT_CONTINUE; // RULE6
			SEL_USER_ONE: return USER_COND_ONE; // RULE7
			SEL_USER_TWO: return USER_COND_TWO; // RULE7
			// Conditions handled by other blocks stay inactive here
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************************
	// Digital outputs
	// ****************************************************
	always_comb begin
		for (int i = 0; i < NUM_DO; i++)
			cond[i] = decode(s.sel[i]);
	end

	for (genvar g = 0; g < NUM_DO; g++) begin : g_dly
		dom_delay u_dly (
			.clk(CORE_CLK),
			.rst(RST),
			.tick(s.tick),
			.cond(cond[g]),
			.on_dly(s.on_dly[g]),
			.off_dly(s.off_dly[g]),
			.state(dly_state[g])
		);
	end

	assign OPEN_COLLECTOR_OUTPUT = s.pins[0];
	assign RELAY_OUTPUT_ONE = s.pins[1];
	assign RELAY_OUTPUT_TWO = s.pins[2];
	assign VIRTUAL_DIGITAL_OUTPUT = s.pins[3];

	// ****************************************************
	// Analog and pulse outputs
	// ****************************************************
	// A process, not an assign: pick reads QUANTITY beyond its argument
	always_comb begin
		std1 = pick(s.ao1_src);
		std2 = pick(s.ao2_src);
	end

	dom_scale u_ao1 (
		.clk(CORE_CLK),
		.rst(RST),
		.std_x(std1),
		.gain(s.ao1_gain),
		.ofs(s.ao1_ofs),
		.y(ANALOG_OUTPUT_ONE)
	);

	dom_scale u_ao2 (
		.clk(CORE_CLK),
		.rst(RST),
		.std_x(std2),
		.gain(s.ao2_gain),
		.ofs(s.ao2_ofs),
		.y(ANALOG_OUTPUT_TWO)
	);

	assign PULSE_FREQUENCY_OUTPUT = s.pulse;

	// ****************************************************
	// APB slave: zero wait states
	// ****************************************************
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PRDATA = s.rdata;
	assign addr_ok = (PADDR[1:0] == 2'b00) && (PADDR <= R_STATUS ||
		(PADDR >= R_ON_DLY && PADDR < R_OFF_DLY + 8'(NUM_DO * 4)));
	assign PSLVERR = PSEL && PENABLE && !addr_ok;

	always_comb begin
		logic signed [31:0] pv;
		int idx;
		pv = '0;
		idx = 0;
		next_s = s;
		// Tick divider for the delay counters
		next_s.tick = 1'b0;
		if (s.div == TICK_W'(TICK_CYCLES - 1)) begin
			next_s.div = '0;
			next_s.tick = 1'b1; // RULE17
		end else begin
			next_s.div = s.div + 1'b1;
		end
		for (int i = 0; i < NUM_DO; i++)
			next_s.pins[i] = dly_state[i] ^ s.pol[i]; // RULE15
		// Pulse rate follows its own selected standard output (pulse_src), clamped to 0..max
		pv = 32'(pick(s.pulse_src)) * signed'(32'(s.pulse_max)) /
			32'(FULL_SCALE);
		if (pv < 0)
			next_s.pulse = '0;
		else if (pv > 32'(s.pulse_max))
			next_s.pulse = s.pulse_max;
		else
			next_s.pulse = pv[Q_W-1:0]; // RULE10
		if (wr_en && addr_ok) begin
			unique case (PADDR)
				R_SEL: begin
					for (int i = 0; i < NUM_DO; i++)
						next_s.sel[i] = PWDATA[8*i +: SEL_W];
				end
				R_POL: next_s.pol = PWDATA[NUM_DO-1:0]; // RULE15
				R_AO_SRC: begin
					next_s.ao1_src = PWDATA[3:0]; // RULE9
					next_s.ao2_src = PWDATA[11:8];
					next_s.pulse_src = PWDATA[19:16];
				end
				R_AO1_GAIN: next_s.ao1_gain =
					clamp_sym(32'(signed'(PWDATA[15:0])), GAIN_LIM); // RULE11
				R_AO1_OFS: next_s.ao1_ofs =
					clamp_sym(32'(signed'(PWDATA[15:0])), OFS_LIM); // RULE12
				R_AO2_GAIN: next_s.ao2_gain =
					clamp_sym(32'(signed'(PWDATA[15:0])), GAIN_LIM); // RULE11
				R_AO2_OFS: next_s.ao2_ofs =
					clamp_sym(32'(signed'(PWDATA[15:0])), OFS_LIM); // RULE12
				R_PULSE_MAX: next_s.pulse_max = PWDATA[15:0];
				R_GUARD: begin
					next_s.guard_lower = PWDATA[15:0];
					next_s.guard_upper = PWDATA[31:16];
				end
				R_HEAT: next_s.heatsink_threshold = PWDATA[15:0];
				default: begin
					idx = int'(PADDR[3:2]);
					// Delays above the range are held at the top value
					// Status is read-only and also lands here
					if (PADDR >= R_ON_DLY && PADDR < R_OFF_DLY)
						next_s.on_dly[idx] = (PWDATA[15:0] > DLY_MAX) ?
							DLY_MAX : PWDATA[15:0]; // RULE13
					else if (PADDR >= R_OFF_DLY)
						next_s.off_dly[idx] = (PWDATA[15:0] > DLY_MAX) ?
							DLY_MAX : PWDATA[15:0]; // RULE14
				end
			endcase
		end
		if (rd_en) begin
			idx = int'(PADDR[3:2]);
			next_s.rdata = '0;
			if (PADDR == R_SEL) begin
				for (int i = 0; i < NUM_DO; i++)
					next_s.rdata[8*i +: SEL_W] = s.sel[i];
			end else if (PADDR == R_POL)
				next_s.rdata = 32'(s.pol);
			else if (PADDR == R_AO_SRC)
				next_s.rdata = {12'h000, s.pulse_src, 4'h0, s.ao2_src,
					4'h0, s.ao1_src};
			else if (PADDR == R_AO1_GAIN)
				next_s.rdata = 32'(s.ao1_gain);
			else if (PADDR == R_AO1_OFS)
				next_s.rdata = 32'(s.ao1_ofs);
			else if (PADDR == R_AO2_GAIN)
				next_s.rdata = 32'(s.ao2_gain);
			else if (PADDR == R_AO2_OFS)
				next_s.rdata = 32'(s.ao2_ofs);
			else if (PADDR == R_PULSE_MAX)
				next_s.rdata = 32'(s.pulse_max);
			else if (PADDR == R_GUARD)
				next_s.rdata = {s.guard_upper, s.guard_lower};
			else if (PADDR == R_HEAT)
				next_s.rdata = 32'(s.heatsink_threshold);
			else if (PADDR == R_STATUS)
				next_s.rdata = {24'h000000, dly_state, cond};
			else if (PADDR >= R_ON_DLY && PADDR < R_OFF_DLY)
				next_s.rdata = 32'(s.on_dly[idx]);
			else if (PADDR >= R_OFF_DLY && addr_ok)
				next_s.rdata = 32'(s.off_dly[idx]);
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s <= '0; // RULE17
			s.ao1_src <= AO1_SRC_RESET; // RULE9
			s.ao2_src <= AO2_SRC_RESET; // RULE9
			s.ao1_gain <= GAIN_ONE; // RULE11
			s.ao2_gain <= GAIN_ONE;
			s.pulse_max <= PULSE_MAX_RESET; // RULE10
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	sequence reverse_sel_s;
		s.sel[1] == SEL_REVERSE && s.on_dly[1] == '0 && !s.pol[1];
	endsequence

	guard_cond_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(s.sel[0] == SEL_AIN_GUARD) |-> (cond[0] ==
		(ANALOG_INPUT_ONE > s.guard_upper ||
		ANALOG_INPUT_ONE < s.guard_lower))) // RULE1
		else $error("guard condition wrong");
	load_cond_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(s.sel[2] == SEL_LOAD_LOST) |-> (cond[2] == LOAD_LOST)) // RULE2
		else $error("load-lost condition wrong");
	reverse_path_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(reverse_sel_s and RUN_REVERSE) ##1 reverse_sel_s
		|=> RELAY_OUTPUT_ONE) // RULE3
		else $error("reverse not reaching relay");
	heat_cond_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(s.sel[3] == SEL_HEATSINK) |-> (cond[3] ==
		(HEATSINK_TEMPERATURE_READING >= s.heatsink_threshold))) // RULE4
		else $error("heatsink condition wrong");
	low_cond_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(s.sel[0] == SEL_LOW_LIMIT) |-> (cond[0] == AT_LOWER_LIMIT)) // RULE5
		else $error("lower limit condition wrong");
	fault_cond_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(s.sel[1] == SEL_FAULT_RUN) |-> (cond[1] == FAULT_CONTINUE)) // RULE6
		else $error("fault condition wrong");
	user_cond_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(s.sel[2] == SEL_USER_TWO) |-> (cond[2] == USER_COND_TWO)) // RULE7
		else $error("user condition two wrong");
	polarity_pin_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		##1 (OPEN_COLLECTOR_OUTPUT == ($past(dly_state[0]) ^
		$past(s.pol[0])))) // RULE15
		else $error("polarity not applied");
	pulse_top_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		PULSE_FREQUENCY_OUTPUT <= $past(s.pulse_max)) // RULE10
		else $error("pulse above maximum");
	tick_rate_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		s.tick |=> !s.tick [*8]) // RULE17
		else $error("tick too frequent");
endmodule

// *** dom_load.sv ***
// Relay load model that stands on the far side of the digital terminals.
// Assumes the terminal drives are levels on the bench clock.
`timescale 1ns/100ps
module dom_load (
	input wire logic clk, // core clock
	input wire logic [3:0] coil, // terminal drives
	output logic [3:0] contact // contact state seen by the load
);
	// Contacts follow the coil one cycle late; a real relay is far slower,
	// so the bench waits a few cycles before it looks.
	always_ff @(posedge clk) begin
		contact <= coil;
	end
endmodule

// *** tb.sv ***
// Self-checking bench of the output terminal mapper.
// Assumes dom_pkg, dom_mapper and dom_load are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
 $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
	import dom_pkg::*;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv, ee, eg;
	logic pready, pslverr, errv;
	logic [Q_W-1:0] ai = 16'h0, heat = 16'h0, pfo;
	logic [5:0] cnd = 6'h0; // load, reverse, low limit, fault, user 1, user 2
	logic [NUM_SRC*Q_W-1:0] qty = '0;
	logic [3:0] pin, contact;
	logic [AO_W-1:0] ao1, ao2;
	int seed = 32'h96de2ab6, fail_count = 0, checked = 0, cyc = 0;
	logic [31:0] exp_q[$], got_q[$];
	string nm_q[$], en;

	always #5 clk = ~clk;

	dom_mapper DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ANALOG_INPUT_ONE(ai), .LOAD_LOST(cnd[0]), .RUN_REVERSE(cnd[1]),
		.HEATSINK_TEMPERATURE_READING(heat), .AT_LOWER_LIMIT(cnd[2]),
		.FAULT_CONTINUE(cnd[3]), .USER_COND_ONE(cnd[4]),
		.USER_COND_TWO(cnd[5]), .QUANTITY(qty),
		.OPEN_COLLECTOR_OUTPUT(pin[0]), .RELAY_OUTPUT_ONE(pin[1]),
		.RELAY_OUTPUT_TWO(pin[2]), .VIRTUAL_DIGITAL_OUTPUT(pin[3]),
		.ANALOG_OUTPUT_ONE(ao1), .ANALOG_OUTPUT_TWO(ao2),
		.PULSE_FREQUENCY_OUTPUT(pfo));
	dom_load u_load (.clk(clk), .coil(pin), .contact(contact));

	// ****************************************************
	// Tasks
	// ****************************************************
	task automatic note(string n, logic [31:0] e);
		nm_q.push_back(n);
		exp_q.push_back(e);
	endtask

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(string n, logic [7:0] a, logic [31:0] e);
		note(n, e);
		apb(1'b0, a, 32'h0);
		got_q.push_back(rdv);
	endtask

	function automatic logic want(logic [5:0] c);
		case (c)
			SEL_AIN_GUARD: return ai > 16'h00c8 || ai < 16'h0064;
			SEL_LOAD_LOST: return cnd[0];
			SEL_REVERSE: return cnd[1];
			SEL_HEATSINK: return heat >= 16'h01f4;
			SEL_LOW_LIMIT: return cnd[2];
			SEL_FAULT_RUN: return cnd[3];
			SEL_USER_ONE: return cnd[4];
			SEL_USER_TWO: return cnd[5];
			default: return 1'b0;
		endcase
	endfunction

	// Expected contacts: selected condition on masked terminals, xor x
	task automatic pins(logic [5:0] c, logic [3:0] m, logic [3:0] x);
		repeat (4) @(posedge clk);
		note("contacts", {28'h0, ({4{want(c)}} & m) ^ x});
		got_q.push_back({28'h0, contact});
	endtask

	task automatic stop_test();
		if (exp_q.size() != got_q.size())
			fail_count++;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************************
	// Result watcher and timeout
	// ****************************************************
	always @(posedge clk) begin
		while (got_q.size() > 0 && exp_q.size() > 0) begin
			en = nm_q.pop_front();
			ee = exp_q.pop_front();
			eg = got_q.pop_front();
			`CHK(en, ee, eg)
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		logic [5:0] codes[8] = '{SEL_AIN_GUARD, SEL_LOAD_LOST, SEL_REVERSE,
			SEL_HEATSINK, SEL_LOW_LIMIT, SEL_FAULT_RUN, SEL_USER_ONE,
			SEL_USER_TWO};
		logic [7:0] ra[10] = '{R_SEL, R_POL, R_AO_SRC, R_AO1_GAIN, R_AO1_OFS,
			R_AO2_GAIN, R_AO2_OFS, R_PULSE_MAX, R_ON_DLY, 8'h30};
		logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h100, 32'h64, 32'h0,
			32'h64, 32'h0, 32'h1388, 32'h0, 32'h0};
		logic [15:0] x;
		logic signed [15:0] y;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i])
			rd("reset value", ra[i], rv[i]);
		note("unmapped error", 32'h1);
		got_q.push_back({31'h0, errv});
		apb(1'b1, R_GUARD, 32'h00c8_0064);
		apb(1'b1, R_HEAT, 32'h1f4);
		apb(1'b1, R_POL, 32'h5);
		foreach (codes[i]) begin
			apb(1'b1, R_SEL, {4{2'b00, codes[i]}});
			repeat (4) begin
				@(posedge clk);
				cnd <= 6'($random(seed));
				ai <= 16'($unsigned($random(seed)) % 300);
				heat <= 16'h190 + 16'($unsigned($random(seed)) % 200);
				pins(codes[i], 4'hf, 4'h5);
			end
		end
		// Delays are one tick, far beyond this run: only the hold is seen
		apb(1'b1, R_POL, 32'h0);
		apb(1'b1, R_SEL, {4{2'b00, SEL_LOAD_LOST}});
		cnd <= 6'h0;
		apb(1'b1, R_ON_DLY + 8'h4, 32'h1);
		apb(1'b1, R_OFF_DLY + 8'h8, 32'h1);
		cnd <= 6'h1;
		pins(SEL_LOAD_LOST, 4'hd, 4'h0);
		cnd <= 6'h0;
		pins(SEL_LOAD_LOST, 4'h0, 4'h4);
		rd("status", R_STATUS, 32'h40);
		rd("select", R_SEL, {4{2'b00, SEL_LOAD_LOST}});
		apb(1'b1, R_STATUS, 32'hff);
		rd("status write", R_ON_DLY + 8'h8, 32'h0);
		apb(1'b1, R_ON_DLY + 8'hc, 32'hffff);
		rd("delay limit", R_ON_DLY + 8'hc, {16'h0, DLY_MAX});
		apb(1'b1, R_AO_SRC, {20'h0, SRC_COMM, 8'h00});
		for (int k = 0; k < 6; k++) begin
			if (k == 3) begin
				apb(1'b1, R_AO1_GAIN, 32'hffff_ffce);
				apb(1'b1, R_AO1_OFS, 32'h320);
			end
			x = 16'($unsigned($random(seed)) % 101 * 100);
			y = 16'($random(seed) % 10001);
			@(posedge clk);
			qty[15:0] <= x;
			qty[SRC_COMM*16 +: 16] <= y;
			repeat (3) @(posedge clk);
			note("ao one", {16'h0, k < 3 ? x : 16'h1f40 - x / 2});
			note("ao two", {16'h0, y[15] ? 16'h0 : y});
			note("pulse", {16'h0, x / 2});
			got_q.push_back({16'h0, ao1});
			got_q.push_back({16'h0, ao2});
			got_q.push_back({16'h0, pfo});
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		note("reset contacts", 32'h0);
		got_q.push_back({28'h0, contact});
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		stop_test();
	end
endmodule
